// >>> rtl/ifsa_top.sv
// two-wire serial slave front end of a 2K x 8 memory without write delay
// assumes SCL, SDA and WP are asynchronous pins sampled by CORE_CLK,
// much slower than it; SDA is open drain, driven low when SDA_OE_N is low
`timescale 1ns/100ps
module ifsa_top #(
   parameter logic [3:0] DEV_CODE = 4'h5 // arbitrary identity value
) (
   input  wire logic CORE_CLK,
   input  wire logic RESETN,
   input  wire logic SCL,
   input  wire logic SDA_IN,
   input  wire logic WP,
   output logic      SDA_OUT,
   output logic      SDA_OE_N
);

   // ----------------------------------------------------------------
   // local constants
   // ----------------------------------------------------------------
   // scl and sda idle high; write-protect pad is pulled low
   localparam logic [2:0] SYNC_INIT = 3'h3;

   // ----------------------------------------------------------------
   // resynchronised pins
   // ----------------------------------------------------------------
   logic [2:0]                  pin_raw;
   logic [2:0]                  pin_s1;
   logic [2:0]                  pin_s2;
   logic                        scl_s;
   logic                        sda_s;
   logic                        wp_s;
   logic                        scl_d;
   logic                        sda_d;

   // ----------------------------------------------------------------
   // bus events
   // ----------------------------------------------------------------
   logic                        scl_rise;
   logic                        scl_fall;
   logic                        start_det;
   logic                        stop_det;

   // ----------------------------------------------------------------
   // protocol engine
   // ----------------------------------------------------------------
   ifsa_pkg::ifsa_state_t       state;
   ifsa_pkg::ifsa_state_t       next_state;
   logic [3:0]                  cnt;
   logic [ifsa_pkg::DATA_W-1:0] rx_byte;
   logic [ifsa_pkg::DATA_W-1:0] next_rx;
   logic                        rx_state;
   logic                        rx_bit;
   logic                        byte_done;
   logic                        dev_done;
   logic                        word_done;
   logic                        wdat_done;
   logic                        type_ok;
   logic                        want_read;
   logic                        read_open;
   logic                        next_ack;
   logic                        ack_pend;
   logic                        is_read;
   logic [2:0]                  page;
   logic                        frame_end;
   logic                        ack_slot;

   // ----------------------------------------------------------------
   // address counter
   // ----------------------------------------------------------------
   logic [ifsa_pkg::ADDR_W-1:0] addr;
   logic                        wr_ok;
   logic                        wr_step;
   logic                        rd_step;
   logic                        addr_step;

   // ----------------------------------------------------------------
   // read path and pin driver
   // ----------------------------------------------------------------
   logic                        mack_rise;
   logic                        mack;
   logic                        fetch;
   logic                        tx_load;
   logic [ifsa_pkg::DATA_W-1:0] tx_byte;
   logic [3:0]                  bit_sel;
   logic                        tx_slot;
   logic                        tx_first;
   logic                        pin_upd;
   logic                        next_pin;

   // ----------------------------------------------------------------
   // write path and array
   // ----------------------------------------------------------------
   logic                        push;
   logic                        buf_in_ready;
   logic [ifsa_pkg::BUF_W-1:0]  buf_in_data;
   logic                        buf_out_valid;
   logic [ifsa_pkg::BUF_W-1:0]  buf_out_data;
   logic                        drain_ready;
   logic                        mem_en;
   logic                        mem_we;
   logic [ifsa_pkg::ADDR_W-1:0] mem_addr;
   logic [ifsa_pkg::DATA_W-1:0] mem_wdata;
   logic [ifsa_pkg::DATA_W-1:0] mem_rdata;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // all three pins enter through two flops
   assign pin_raw = {WP, SDA_IN, SCL};

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         pin_s1 <= SYNC_INIT;
         pin_s2 <= SYNC_INIT;
      end else begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
      end
   end

   // named views of the second stage
   assign scl_s = pin_s2[0];
   assign sda_s = pin_s2[1];
   assign wp_s  = pin_s2[2];

   // previous levels for edge finding; idle high so no false edge
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // ----------------------------------------------------------------
   // bus conditions
   // ----------------------------------------------------------------
   // clock edges, and data moving while the clock is high
   assign scl_rise  = scl_s & ~scl_d;
   assign scl_fall  = ~scl_s & scl_d;
   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

   // ----------------------------------------------------------------
   // byte framing decode
   // ----------------------------------------------------------------
   // receiving states shift the data line in
   assign rx_state  = (state == ifsa_pkg::ST_DEV) | (state == ifsa_pkg::ST_WORD)
                    | (state == ifsa_pkg::ST_WDAT);
   assign next_rx   = {rx_byte[ifsa_pkg::DATA_W-2:0], sda_s};
   assign rx_bit    = scl_rise & rx_state & (cnt <= ifsa_pkg::CNT_LAST);
   assign byte_done = scl_rise & rx_state & (cnt == ifsa_pkg::CNT_LAST);
   assign dev_done  = byte_done & (state == ifsa_pkg::ST_DEV);
   assign word_done = byte_done & (state == ifsa_pkg::ST_WORD);
   assign wdat_done = byte_done & (state == ifsa_pkg::ST_WDAT);

   // slave byte fields
   assign type_ok   = (next_rx[ifsa_pkg::TYPE_MSB:ifsa_pkg::TYPE_LSB] == DEV_CODE);
   assign want_read = next_rx[ifsa_pkg::RW_BIT];
   assign read_open = dev_done & type_ok & want_read;

   // ninth clock slots
   assign ack_slot  = scl_fall & (cnt == ifsa_pkg::CNT_ACK);
   assign frame_end = scl_fall & (cnt == ifsa_pkg::CNT_END);

   // ----------------------------------------------------------------
   // acknowledge decision
   // ----------------------------------------------------------------
   // slave byte: code match, never busy; word byte: always; data: unless protected
   assign wr_ok    = ~wp_s & buf_in_ready;
   assign next_ack = dev_done ? type_ok : (word_done | wr_ok);

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ack_pend <= 1'b0;
      end else if (start_det | stop_det | frame_end) begin
         ack_pend <= 1'b0;
      end else if (byte_done) begin
         ack_pend <= next_ack;
      end
   end

   // ----------------------------------------------------------------
   // state machine
   // ----------------------------------------------------------------
   // start and stop override any frame in progress
   always_comb begin
      next_state = state;
      if (start_det) begin
         next_state = ifsa_pkg::ST_DEV;
      end else if (stop_det) begin
         next_state = ifsa_pkg::ST_IDLE;
      end else if (frame_end) begin
         unique case (state)
            ifsa_pkg::ST_IDLE: next_state = ifsa_pkg::ST_IDLE;
            ifsa_pkg::ST_DEV:  next_state = !ack_pend ? ifsa_pkg::ST_IDLE :
                                            (is_read ? ifsa_pkg::ST_RDAT : ifsa_pkg::ST_WORD);
            ifsa_pkg::ST_WORD: next_state = ifsa_pkg::ST_WDAT;
            ifsa_pkg::ST_WDAT: next_state = ack_pend ? ifsa_pkg::ST_WDAT :
                                            ifsa_pkg::ST_IDLE;
            ifsa_pkg::ST_RDAT: next_state = mack ? ifsa_pkg::ST_RDAT :
                                            ifsa_pkg::ST_IDLE;
            default:           next_state = ifsa_pkg::ST_IDLE;
         endcase
      end
   end

   // state register
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state <= ifsa_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // bit counter and receive shifter
   // ----------------------------------------------------------------
   // counts rising clock edges of one nine-clock frame
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cnt <= ifsa_pkg::CNT_ZERO;
      end else if (start_det | stop_det | frame_end) begin
         cnt <= ifsa_pkg::CNT_ZERO;
      end else if (scl_rise & (state != ifsa_pkg::ST_IDLE)) begin
         cnt <= cnt + 4'h1;
      end
   end

   // msb arrives first
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rx_byte <= '0;
      end else if (rx_bit) begin
         rx_byte <= next_rx;
      end
   end

   // page and direction of the current transaction
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         page    <= 3'h0;
         is_read <= 1'b0;
      end else if (dev_done & type_ok) begin
         page    <= next_rx[ifsa_pkg::PAGE_MSB:ifsa_pkg::PAGE_LSB];
         is_read <= want_read;
      end
   end

   // ----------------------------------------------------------------
   // address counter
   // ----------------------------------------------------------------
   // steps after each stored or sent byte; wraps at the top
   assign wr_step   = wdat_done & wr_ok;
   assign rd_step   = scl_rise & (state == ifsa_pkg::ST_RDAT) & (cnt == ifsa_pkg::CNT_LAST);
   assign addr_step = wr_step | rd_step;

   // kept between transactions for current-address reads
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         addr <= ifsa_pkg::ADDR_BASE;
      end else if (read_open) begin
         addr <= {next_rx[ifsa_pkg::PAGE_MSB:ifsa_pkg::PAGE_LSB],
                  addr[ifsa_pkg::DATA_W-1:0]};
      end else if (word_done) begin
         addr <= {page, next_rx};
      end else if (addr_step) begin
         addr <= addr + ifsa_pkg::ADDR_ONE;
      end
   end

   // ----------------------------------------------------------------
   // write path: one byte at a time into the buffer
   // ----------------------------------------------------------------
   // no page buffer: each byte goes straight to its own cell
   assign push        = wr_step;
   assign buf_in_data = {addr, next_rx};
   assign drain_ready = 1'b1; // the array takes a byte every cycle

   ifsa_buf #(
      .W         (ifsa_pkg::BUF_W)
   ) u_buf (
      .clk       (CORE_CLK),
      .rst_n     (RESETN),
      .in_valid  (push),
      .in_ready  (buf_in_ready),
      .in_data   (buf_in_data),
      .out_valid (buf_out_valid),
      .out_ready (drain_ready),
      .out_data  (buf_out_data)
   );

   // ----------------------------------------------------------------
   // array port sharing
   // ----------------------------------------------------------------
   // writes win; reads only happen in read frames, when the buffer is empty
   assign mem_en    = buf_out_valid | fetch;
   assign mem_we    = buf_out_valid;
   assign mem_addr  = buf_out_valid ? buf_out_data[ifsa_pkg::BUF_W-1:ifsa_pkg::DATA_W] : addr;
   assign mem_wdata = buf_out_data[ifsa_pkg::DATA_W-1:0];

   ifsa_mem u_mem (
      .clk       (CORE_CLK),
      .en        (mem_en),
      .we        (mem_we),
      .addr      (mem_addr),
      .wdata     (mem_wdata),
      .rdata     (mem_rdata)
   );

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // master acknowledge sampled in the ninth clock of a read byte
   assign mack_rise = scl_rise & (state == ifsa_pkg::ST_RDAT) & (cnt == ifsa_pkg::CNT_ACK);

   // a low ninth bit asks for another byte
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         mack <= 1'b0;
      end else if (start_det | stop_det) begin
         mack <= 1'b0;
      end else if (mack_rise) begin
         mack <= ~sda_s;
      end
   end

   // fetch the byte, then load it one cycle after the array answers
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         fetch   <= 1'b0;
         tx_load <= 1'b0;
      end else begin
         fetch   <= read_open | (mack_rise & ~sda_s);
         tx_load <= fetch;
      end
   end

   // byte to be sent
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         tx_byte <= '0;
      end else if (tx_load) begin
         tx_byte <= mem_rdata;
      end
   end

   // ----------------------------------------------------------------
   // data pin driver
   // ----------------------------------------------------------------
   // msb goes out on the fall that ends the previous frame
   assign tx_first = frame_end & (next_state == ifsa_pkg::ST_RDAT);
   assign tx_slot  = scl_fall & (state == ifsa_pkg::ST_RDAT) & (cnt < ifsa_pkg::CNT_ACK);
   assign bit_sel  = ifsa_pkg::CNT_LAST - cnt;
   assign pin_upd  = tx_first | tx_slot | ack_slot | frame_end;

   // a one releases the line, a zero pulls it low
   assign next_pin = tx_first ? tx_byte[ifsa_pkg::DATA_W-1] :
                     tx_slot  ? tx_byte[bit_sel[2:0]] :
                     ~(ack_slot & rx_state & ack_pend);

   // both pin outputs come from flops
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         SDA_OUT  <= 1'b1;
         SDA_OE_N <= 1'b1;
      end else if (start_det | stop_det) begin
         SDA_OUT  <= 1'b1;
         SDA_OE_N <= 1'b1;
      end else if (pin_upd) begin
         SDA_OUT  <= next_pin;
         SDA_OE_N <= next_pin;
      end
   end

   // ----------------------------------------------------------------
   // protocol checks
   // ----------------------------------------------------------------
   // a stored byte reaches the array within a few cycles
   sequence s_drain;
      ##[1:3] (mem_en && mem_we);
   endsequence

   // bus released and engine idle
   sequence s_released;
      (state == ifsa_pkg::ST_IDLE) && SDA_OE_N;
   endsequence

   property p_commit;
      @(posedge CORE_CLK) disable iff (!RESETN)
      push |-> s_drain;
   endproperty
   a_commit: assert property (p_commit)
      else $error("stored byte did not reach the array");

   property p_wrap;
      @(posedge CORE_CLK) disable iff (!RESETN)
      addr_step && (addr == ifsa_pkg::ADDR_TOP) |=> (addr == ifsa_pkg::ADDR_BASE);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("address did not wrap to zero");

   property p_wp_noack;
      @(posedge CORE_CLK) disable iff (!RESETN)
      wdat_done && wp_s |-> !push ##1 !ack_pend;
   endproperty
   a_wp_noack: assert property (p_wp_noack)
      else $error("protected byte stored or acknowledged");

   property p_wp_hold;
      @(posedge CORE_CLK) disable iff (!RESETN)
      wdat_done && wp_s |=> $stable(addr);
   endproperty
   a_wp_hold: assert property (p_wp_hold)
      else $error("address moved on a protected write");

   property p_abort;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (start_det || stop_det) |-> !push ##1 (cnt == ifsa_pkg::CNT_ZERO);
   endproperty
   a_abort: assert property (p_abort)
      else $error("cut byte was not dropped");

   property p_stop_idle;
      @(posedge CORE_CLK) disable iff (!RESETN)
      stop_det |=> s_released;
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("stop did not return to idle");

   property p_start_release;
      @(posedge CORE_CLK) disable iff (!RESETN)
      start_det |=> (state == ifsa_pkg::ST_DEV) && SDA_OE_N;
   endproperty
   a_start_release: assert property (p_start_release)
      else $error("start did not release the bus");

   property p_type_nack;
      @(posedge CORE_CLK) disable iff (!RESETN)
      dev_done && !type_ok |=> !ack_pend;
   endproperty
   a_type_nack: assert property (p_type_nack)
      else $error("foreign slave byte acknowledged");

endmodule // ifsa_top

// >>> rtl/ifsa_pkg.sv
// constants and state codes of the two-wire nonvolatile memory slave
// assumes one core clock; bus pins arrive asynchronously and are resynchronised
// Operation
// - every stored write byte is acknowledged; write runs have no length limit
// - address counter wraps from 7FFh to 000h for reads and writes
// - no busy time after a write; slave byte is acknowledged at once
// - byte is committed after its 8th bit and before its acknowledge
// - START or STOP before the 8th data bit aborts, location unchanged
// - no page buffer; each byte goes to its own location on arrival
// - write-protect high: data bytes neither stored nor acknowledged
// - protected write attempt leaves the address counter unchanged
// - write-protect low or unconnected leaves the array writable
// - read start address is page bits plus low eight latched bits
// - current-address read continues after the previous access, no word phase
// - after the read slave byte, data shifts out msb first on next clock
// - read advances address per byte; master acknowledge sends the next byte
// - STOP or START in the 9th clock also ends a read; bus released
// - word-address byte is loaded into the address latch, then acknowledged
// - repeated START after word address aborts the write; read follows from there
// - slave bits 3..1 select a 256-byte block, bit 0 is direction
// - word byte gives low eight bits, joined with page bits into 11 bits
// - STOP during any operation aborts it and returns to idle
// - slave bits 7..4 carry the fixed device-type code
package ifsa_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int ADDR_W    = 11;
   localparam int DATA_W    = 8;
   localparam int MEM_DEPTH = 2048;
   localparam int BUF_W     = ADDR_W + DATA_W;

   // ----------------------------------------------------------------
   // slave byte fields, bit counts, address ends
   // ----------------------------------------------------------------
   localparam int TYPE_MSB = 7;
   localparam int TYPE_LSB = 4;
   localparam int PAGE_MSB = 3;
   localparam int PAGE_LSB = 1;
   localparam int RW_BIT   = 0;
   localparam logic [3:0] CNT_LAST = 4'h7;
   localparam logic [3:0] CNT_ACK  = 4'h8;
   localparam logic [3:0] CNT_END  = 4'h9;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_TOP  = 11'h7FF;
   localparam logic [ADDR_W-1:0] ADDR_BASE = 11'h000;
   localparam logic [ADDR_W-1:0] ADDR_ONE  = 11'h001;

   // ----------------------------------------------------------------
   // protocol states, gray along the write path
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_DEV  = 3'h1,
      ST_WORD = 3'h3,
      ST_WDAT = 3'h2,
      ST_RDAT = 3'h6
   } ifsa_state_t;

endpackage

// >>> rtl/ifsa_mem.sv
// byte array of the memory, one port, read data from a register
// assumes the caller never reads and writes in the same cycle
`timescale 1ns/100ps
module ifsa_mem (
   input  wire logic                         clk,
   input  wire logic                         en,
   input  wire logic                         we,
   input  wire logic [ifsa_pkg::ADDR_W-1:0]  addr,
   input  wire logic [ifsa_pkg::DATA_W-1:0]  wdata,
   output logic      [ifsa_pkg::DATA_W-1:0]  rdata
);

   logic [ifsa_pkg::DATA_W-1:0] cells [ifsa_pkg::MEM_DEPTH];

   // ----------------------------------------------------------------
   // array access
   // ----------------------------------------------------------------
   // write stores, read registers the cell
   always_ff @(posedge clk) begin
      if (en && we) begin
         cells[addr] <= wdata;
      end else if (en) begin
         rdata <= cells[addr];
      end
   end

endmodule // ifsa_mem

// >>> rtl/ifsa_buf.sv
// two-entry buffer with valid and ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/100ps
module ifsa_buf #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);

   logic [W-1:0] slot [2];
   logic         wp;
   logic         rp;
   logic [1:0]   fill;
   wire          do_in  = in_valid & in_ready;
   wire          do_out = out_valid & out_ready;

   // ----------------------------------------------------------------
   // flags and output
   // ----------------------------------------------------------------
   assign in_ready  = (fill != 2'h2);
   assign out_valid = (fill != 2'h0);
   assign out_data  = slot[rp];

   // pointers and fill count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp   <= 1'b0;
         rp   <= 1'b0;
         fill <= 2'h0;
      end else begin
         wp   <= wp ^ do_in;
         rp   <= rp ^ do_out;
         fill <= fill + {1'b0, do_in} - {1'b0, do_out};
      end
   end

   // storage
   always_ff @(posedge clk) begin
      if (do_in) begin
         slot[wp] <= in_data;
      end
   end

endmodule // ifsa_buf

// >>> bench/ifsa_master.sv
// two-wire bus master model: makes the bus clock, drives data open drain
// assumes a pull-up on data, so released data reads high
`timescale 1ns/100ps
module ifsa_master (
   output logic      scl,
   output logic      sda_o,
   input  wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_o = 1'b1;
   end
   // one quarter of a 160 ns bus clock
   task automatic ph(input logic d, input logic c);
      sda_o = d;
      scl = c;
      #40;
   endtask
   // data is set while the clock is low and sampled while high
   task automatic bitio(input logic b, output logic r);
      ph(b, 1'b0);
      ph(b, 1'b1);
      r = sda;
      ph(b, 1'b1);
      ph(b, 1'b0);
   endtask
   // msb first, then the acknowledge clock
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                       output logic k);
      for (int i = 7; i >= 0; i--) bitio(d[i], q[i]);
      bitio(a, k);
   endtask
   task automatic start();
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
      ph(1'b0, 1'b1);
      ph(1'b0, 1'b0);
   endtask
   task automatic stop();
      ph(1'b0, 1'b0);
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
   endtask
endmodule // ifsa_master

// >>> bench/i2c_fram_slave_access_tb_top.sv
// self-checking bench of the memory slave, driven by the master model
`timescale 1ns/100ps
module i2c_fram_slave_access_tb_top;
   logic core_clk, resetn, wp, scl, sda_m, sda_out, sda_oe_n, k;
   wire        sda = sda_m & (sda_oe_n | sda_out);
   logic [7:0] q;
   int         error_cnt = 0;
   int         checks_done = 0;
   logic [18:0] rows [4] = '{19'h123A5, 19'h25E3C, 19'h70000, 19'h4FFFF};
   ifsa_master m (.scl(scl), .sda_o(sda_m), .sda(sda));
   ifsa_top uut (.CORE_CLK(core_clk), .RESETN(resetn), .SCL(scl), .SDA_IN(sda),
      .WP(wp), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // write slave byte and word address
   task automatic addr(input logic [10:0] a);
      m.start();
      m.xfer({4'h5, a[10:8], 1'b0}, 1'b1, q, k);
      chk({7'h00, k}, 8'h00);
      m.xfer(a[7:0], 1'b1, q, k);
      chk({7'h00, k}, 8'h00);
   endtask
   task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic ka);
      addr(a);
      m.xfer(d, 1'b1, q, k);
      chk({7'h00, k}, {7'h00, ka});
      m.stop();
   endtask
   // read from the current place, one byte, ended by no-acknowledge
   task automatic cur(input logic [2:0] p, input logic [7:0] e);
      m.start();
      m.xfer({4'h5, p, 1'b1}, 1'b1, q, k);
      m.xfer(8'hFF, 1'b1, q, k);
      chk(q, e);
      m.stop();
   endtask
   task automatic rd(input logic [10:0] a, input logic [7:0] e);
      addr(a);
      cur(a[10:8], e);
   endtask
   initial begin
      resetn = 1'b0;
      wp = 1'b0;
      repeat (6) @(negedge core_clk);
      resetn = 1'b1;
      repeat (4) @(negedge core_clk);
      foreach (rows[i]) begin
         wr(rows[i][18:8], rows[i][7:0], 1'b0);
         rd(rows[i][18:8], rows[i][7:0]);
      end
      @(negedge core_clk) wp = 1'b1;
      wr(11'h123, 8'h3C, 1'b1);
      @(negedge core_clk) wp = 1'b0;
      rd(11'h123, 8'hA5);
      // stop inside a data byte leaves the location alone
      addr(11'h123);
      repeat (4) m.bitio(1'b0, k);
      m.stop();
      rd(11'h123, 8'hA5);
      wr(11'h7FF, 8'hC3, 1'b0);
      wr(11'h000, 8'h96, 1'b0);
      rd(11'h7FF, 8'hC3);
      cur(3'h0, 8'h96);
      // two-byte write run, then a two-byte read run
      addr(11'h200);
      m.xfer(8'h11, 1'b1, q, k);
      m.xfer(8'h22, 1'b1, q, k);
      chk({7'h00, k}, 8'h00);
      addr(11'h200);
      m.start();
      m.xfer({4'h5, 3'h2, 1'b1}, 1'b1, q, k);
      m.xfer(8'hFF, 1'b0, q, k);
      chk(q, 8'h11);
      m.xfer(8'hFF, 1'b1, q, k);
      chk(q, 8'h22);
      m.stop();
      m.start();
      m.xfer(8'h30, 1'b1, q, k);
      chk({7'h00, k}, 8'h01);
      m.stop();
      summarize();
   end
   initial begin
      #400us;
      error_cnt++;
      summarize();
   end
endmodule // i2c_fram_slave_access_tb_top
